// ### hw/elt_pkg.sv
// Constants, field layouts and carrier types for the launch token checker
//=============================================
package elt_pkg;
  //=============================================
  // Register map
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_RESULT   = 8'h08;
  localparam logic [7:0] REG_INT_STAT = 8'h0c;
  localparam logic [7:0] REG_INT_MASK = 8'h10;
  localparam int         CTRL_START   = 0;
  localparam int         ST_BUSY      = 0;
  localparam int         ST_ZERO      = 1;
  localparam int         ST_INIT      = 2;
  localparam int         ST_ARITH     = 3;
  localparam int         INT_DONE     = 0;
  localparam int         INT_FAIL     = 1;
  localparam int         INT_GP       = 2;
  localparam int         INT_PF       = 3;
  localparam logic [3:0]  INT_RESET   = 4'h0;
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
  //=============================================
  // Result codes
  localparam logic [31:0] RES_OK             = 32'h0000_0000;
  localparam logic [31:0] ERR_INVALID_MEAS   = 32'h0000_0002;
  localparam logic [31:0] ERR_INVALID_TOKEN  = 32'h0000_0010;
  localparam logic [31:0] ERR_INVALID_SVN    = 32'h0000_0020;
  localparam logic [31:0] ERR_INVALID_TATTR  = 32'h0000_0040;
  //=============================================
  // Field positions and constants
  localparam int          DEBUG_BIT  = 1;
  localparam int          RSV_W      = 416;
  localparam int          PAD_W      = 2816;
  localparam int          MAC_MSG_W  = 1536;
  localparam logic [15:0] LAUNCH_KEY = 16'h0000;
  localparam logic [15:0] PAD_LOW    = 16'h0100;
  localparam logic [159:0] PAD_DER   = 160'h2004000501020403650148866009060d30313000;
  //=============================================
  // Carrier types
  typedef struct packed {
    logic [RSV_W-1:0] reserved;
    logic [31:0]      valid;
    logic [127:0]     maskedAttr;
    logic [127:0]     attributes;
    logic [127:0]     processor_security_version;
    logic [15:0]      prodId;
    logic [15:0]      svn;
    logic [255:0]     keyId;
    logic [31:0]      maskedMisc;
    logic [255:0]     enclave_measurement;
    logic [255:0]     signer_measurement;
    logic [127:0]     mac;
  } elt_token_s;
  typedef struct packed {
    logic [15:0]      keyName;
    logic [15:0]      prodId;
    logic [15:0]      svn;
    logic [127:0]     ownerEpoch;
    logic [127:0]     attributes;
    logic [127:0]     attrMask;
    logic [255:0]     enclave_measurement;
    logic [255:0]     signer_measurement;
    logic [255:0]     keyId;
    logic [127:0]     fuses;
    logic [127:0]     processor_security_version;
    logic [31:0]      misc;
    logic [31:0]      miscMask;
    logic [PAD_W-1:0] padding;
  } elt_keydep_s;
  typedef struct packed {
    logic [255:0]     enclave_measurement;
    logic [255:0]     signer_measurement;
    logic [15:0]      prodId;
    logic [15:0]      svn;
    logic [PAD_W-1:0] padding;
  } elt_commit_s;
  typedef struct packed {
    logic misaligned;
    logic notInCache;
    logic secsBusy;
    logic notValidSecs;
    logic alreadyInit;
    logic mrInUse;
    logic accessFault;
  } elt_fault_s;
  // Fixed padding for key derivation
  function automatic logic [PAD_W-1:0] keyPadding();
    keyPadding = {PAD_DER, {2640{1'b1}}, PAD_LOW};
  endfunction : keyPadding
endpackage : elt_pkg

// ### hw/elt_check.sv
// Ordered token comparisons, first failure wins
`timescale 1ns/100ps
module elt_check (
  input  elt_pkg::elt_token_s token,
  input  wire logic [127:0]   secsAttr,
  input  wire logic [255:0]   mrEnclaveFinal,
  input  wire logic [255:0]   signer,
  input  wire logic [255:0]   vendorKeyHash,
  input  wire logic [127:0]   procSvn,
  output logic                bypass,
  output logic [31:0]         earlyCode,
  output logic [31:0]         lateCode
);
  //=============================================
  // Checks before the MAC
  always_comb
  begin
    bypass    = ~token.valid[0];
    earlyCode = elt_pkg::RES_OK;
    if (bypass)
    begin
      if (signer != vendorKeyHash)
        earlyCode = elt_pkg::ERR_INVALID_TOKEN;
    end
    else if (token.maskedAttr[elt_pkg::DEBUG_BIT] && !secsAttr[elt_pkg::DEBUG_BIT])
      earlyCode = elt_pkg::ERR_INVALID_TOKEN;
    else if ((|token.reserved) || (|token.valid[31:1]))
      earlyCode = elt_pkg::ERR_INVALID_TOKEN;
    else if (token.processor_security_version > procSvn)
      earlyCode = elt_pkg::ERR_INVALID_SVN;
  end
  //=============================================
  // Checks after the MAC
  always_comb
  begin
    lateCode = elt_pkg::RES_OK;
    if ((token.enclave_measurement != mrEnclaveFinal) || (token.signer_measurement != signer))
      lateCode = elt_pkg::ERR_INVALID_MEAS;
    else if (token.attributes != secsAttr)
      lateCode = elt_pkg::ERR_INVALID_TATTR;
  end
endmodule : elt_check

// ### hw/elt_launch_check.sv
// Launch token check sequencer with register port and commit
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/100ps
module elt_launch_check (
  input  wire logic                 clock,
  input  wire logic                 nrst,
  input  wire logic [7:0]           regAddr,
  input  wire logic [31:0]          regWData,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output logic [31:0]               regRData,
  input  elt_pkg::elt_token_s       token,
  input  wire logic [1535:0]        tokenImage,
  input  wire logic [127:0]         secsAttr,
  input  wire logic [255:0]         mrEnclaveFinal,
  input  wire logic [255:0]         signerDigest,
  input  wire logic [255:0]         vendorKeyHash,
  input  wire logic [127:0]         procSvn,
  input  wire logic [127:0]         ownerEpoch,
  input  wire logic [127:0]         sealFuses,
  input  wire logic [15:0]          sigProdId,
  input  wire logic [15:0]          sigSvn,
  input  wire logic [2815:0]        sigPadding,
  input  elt_pkg::elt_fault_s       faults,
  output elt_pkg::elt_keydep_s      keyDep,
  output logic [1535:0]             macMsg,
  output logic                      cryptoValid,
  input  wire logic                 cryptoDone,
  input  wire logic [127:0]         cryptoMac,
  output elt_pkg::elt_commit_s      commitData,
  output logic                      commitValid,
  output logic                      secsInitialized,
  output logic                      gpFault,
  output logic                      pfFault,
  output logic                      irq
);
  typedef enum {S_IDLE, S_CHECK, S_MAC, S_LATE} elt_state_e;

  elt_state_e           state_r;
  logic [255:0]         signer_r;
  logic                 zeroFlag_r;
  logic [4:0]           arith_r;
  logic [31:0]          result_r;
  logic [3:0]           intStat_r;
  logic [3:0]           intMask_r;
  logic [3:0]           intSet;
  logic                 bypass;
  logic [31:0]          earlyCode;
  logic [31:0]          lateCode;
  logic                 start;
  logic                 exitNow;
  logic                 failNow;
  logic [31:0]          exitCode;
  logic                 doCommit;
  logic                 gpCause;
  logic                 pfCause;

  assign start = regWr && (regAddr == elt_pkg::REG_CTRL) && regWData[elt_pkg::CTRL_START]
                 && (state_r == S_IDLE);

  elt_check u_check (
    .token          (token),
    .secsAttr       (secsAttr),
    .mrEnclaveFinal (mrEnclaveFinal),
    .signer         (signer_r),
    .vendorKeyHash  (vendorKeyHash),
    .procSvn        (procSvn),
    .bypass         (bypass),
    .earlyCode      (earlyCode),
    .lateCode       (lateCode)
  );

  //=============================================
  // Fault screening at start
  // gpFault and pfFault causes
  assign gpCause = faults.misaligned || faults.secsBusy || faults.alreadyInit
                   || faults.mrInUse;
  assign pfCause = faults.notInCache || faults.notValidSecs || faults.accessFault;

  //=============================================
  // Exit decode
  always_comb
  begin
    exitNow  = 1'b0;
    failNow  = 1'b0;
    exitCode = elt_pkg::RES_OK;
    doCommit = 1'b0;
    case (state_r)
      S_CHECK:
      begin
        if (earlyCode != elt_pkg::RES_OK)
        begin
          exitNow  = 1'b1;
          failNow  = 1'b1;
          exitCode = earlyCode;
        end
        else if (bypass)
        begin
          exitNow  = 1'b1;
          doCommit = 1'b1;
        end
      end
      S_MAC:
      begin
        if (cryptoDone && (cryptoMac != token.mac))
        begin
          exitNow  = 1'b1;
          failNow  = 1'b1;
          exitCode = elt_pkg::ERR_INVALID_TOKEN;
        end
      end
      S_LATE:
      begin
        exitNow = 1'b1;
        if (lateCode != elt_pkg::RES_OK)
        begin
          failNow  = 1'b1;
          exitCode = lateCode;
        end
        else
          doCommit = 1'b1;
      end
      default:
      begin
        exitNow = 1'b0;
      end
    endcase
  end

  //=============================================
  // Sequencer
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      state_r <= S_IDLE;
    else
      case (state_r)
        S_IDLE:  if (start && !gpCause && !pfCause) state_r <= S_CHECK;
        S_CHECK: state_r <= exitNow ? S_IDLE : S_MAC;
        S_MAC:   if (cryptoDone) state_r <= exitNow ? S_IDLE : S_LATE;
        S_LATE:  state_r <= S_IDLE;
        default: state_r <= S_IDLE;
      endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      signer_r <= '0;
    else if (start)
      signer_r <= signerDigest;
  end

  //=============================================
  // Key derivation and CMAC request
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cryptoValid <= 1'b0;
      keyDep      <= '0;
      macMsg      <= '0;
    end
    else if ((state_r == S_CHECK) && !exitNow)
    begin
      cryptoValid         <= 1'b1;
      keyDep.keyName    <= elt_pkg::LAUNCH_KEY;
      keyDep.prodId     <= token.prodId;
      keyDep.svn        <= token.svn;
      keyDep.ownerEpoch <= ownerEpoch;
      keyDep.attributes <= token.maskedAttr;
      keyDep.attrMask   <= '0;
      keyDep.enclave_measurement  <= '0;
      keyDep.signer_measurement   <= '0;
      keyDep.keyId      <= token.keyId;
      keyDep.fuses      <= sealFuses;
      keyDep.processor_security_version     <= token.processor_security_version;
      keyDep.misc       <= token.maskedMisc;
      keyDep.miscMask   <= '0;
      keyDep.padding    <= elt_pkg::keyPadding();
      macMsg            <= tokenImage;
    end
    else if (cryptoDone)
      cryptoValid <= 1'b0;
  end

  //=============================================
  // Commit to control structure
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      commitValid     <= 1'b0;
      commitData      <= '0;
      secsInitialized <= 1'b0;
    end
    else
    begin
      commitValid <= doCommit;
      if (doCommit)
      begin
        commitData.enclave_measurement <= mrEnclaveFinal;
        commitData.signer_measurement  <= signer_r;
        commitData.prodId    <= sigProdId;
        commitData.svn       <= sigSvn;
        commitData.padding   <= sigPadding;
        secsInitialized      <= 1'b1;
      end
    end
  end

  //=============================================
  // Outcome flags and result
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      zeroFlag_r <= 1'b0;
      arith_r    <= '0;
      result_r   <= elt_pkg::RESULT_RESET;
    end
    else if (exitNow)
    begin
      zeroFlag_r <= failNow;
      arith_r    <= '0;
      result_r   <= exitCode;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      gpFault <= 1'b0;
      pfFault <= 1'b0;
    end
    else
    begin
      gpFault <= start && gpCause;
      pfFault <= start && !gpCause && pfCause;
    end
  end

  //=============================================
  // Interrupt status and mask
  always_comb
  begin
    intSet                    = '0;
    intSet[elt_pkg::INT_DONE] = exitNow;
    intSet[elt_pkg::INT_FAIL] = failNow;
    intSet[elt_pkg::INT_GP]   = start && gpCause;
    intSet[elt_pkg::INT_PF]   = start && !gpCause && pfCause;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      intStat_r <= elt_pkg::INT_RESET;
    else if (regWr && (regAddr == elt_pkg::REG_INT_STAT))
      intStat_r <= (intStat_r & ~regWData[3:0]) | intSet;
    else
      intStat_r <= intStat_r | intSet;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      intMask_r <= elt_pkg::INT_RESET;
    else if (regWr && (regAddr == elt_pkg::REG_INT_MASK))
      intMask_r <= regWData[3:0];
  end

  assign irq = |(intStat_r & intMask_r);

  //=============================================
  // Register reads
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      regRData <= '0;
    else if (regRd)
      case (regAddr)
        elt_pkg::REG_STATUS:   regRData <= {24'h0, arith_r, secsInitialized, zeroFlag_r,
                                            state_r != S_IDLE};
        elt_pkg::REG_RESULT:   regRData <= result_r;
        elt_pkg::REG_INT_STAT: regRData <= {28'h0, intStat_r};
        elt_pkg::REG_INT_MASK: regRData <= {28'h0, intMask_r};
        default:               regRData <= '0;
      endcase
    else
      regRData <= '0;
  end

  //=============================================
  // Checks
  a_vendor_bypass: assert property (@(posedge clock) disable iff (!nrst)
    (state_r == S_CHECK && bypass && signer_r == vendorKeyHash) |=> commitValid)
    else $error("bypass did not commit");
  a_debug_pair: assert property (@(posedge clock) disable iff (!nrst)
    (state_r == S_CHECK && !bypass && token.maskedAttr[elt_pkg::DEBUG_BIT]
     && !secsAttr[elt_pkg::DEBUG_BIT]) |=> (result_r == elt_pkg::ERR_INVALID_TOKEN))
    else $error("debug pairing not rejected");
  a_svn_bound: assert property (@(posedge clock) disable iff (!nrst)
    (state_r == S_CHECK && earlyCode == elt_pkg::ERR_INVALID_SVN) |=>
    (zeroFlag_r && state_r == S_IDLE && !cryptoValid))
    else $error("svn failure not reported");
  a_key_pad: assert property (@(posedge clock) disable iff (!nrst)
    $rose(cryptoValid) |-> keyDep.padding[15:0] == elt_pkg::PAD_LOW)
    else $error("padding low word wrong");
  a_key_zero: assert property (@(posedge clock) disable iff (!nrst)
    cryptoValid |-> (keyDep.signer_measurement == '0 && keyDep.attrMask == '0))
    else $error("key dependency not zeroed");
  a_mac_fail: assert property (@(posedge clock) disable iff (!nrst)
    (state_r == S_MAC && cryptoDone && cryptoMac != token.mac) |=>
    (result_r == elt_pkg::ERR_INVALID_TOKEN && !commitValid))
    else $error("mac mismatch not rejected");
  a_commit_init: assert property (@(posedge clock) disable iff (!nrst)
    commitValid |-> (secsInitialized && !zeroFlag_r && result_r == elt_pkg::RES_OK))
    else $error("commit without success");
  a_fail_flag: assert property (@(posedge clock) disable iff (!nrst)
    (exitNow && failNow) |=> (zeroFlag_r && result_r != elt_pkg::RES_OK && arith_r == '0))
    else $error("failure flags wrong");
  a_gp_fault: assert property (@(posedge clock) disable iff (!nrst)
    (start && gpCause) |=> (gpFault && !pfFault) ##1 (state_r == S_IDLE && !gpFault))
    else $error("protection fault pulse wrong");
  a_no_commit_fail: assert property (@(posedge clock) disable iff (!nrst)
    (exitNow && failNow) |=> !commitValid)
    else $error("commit after failure");
endmodule : elt_launch_check

// ### tb/elt_launch_check_tb.sv
// Self-checking bench for the launch token checker
`timescale 1ns/100ps
module elt_launch_check_tb;
  //=============================================
  // Signals and fixed inputs
  logic                 clock;
  logic                 nrst;
  logic [7:0]           regAddr;
  logic [31:0]          regWData;
  logic                 regWr;
  logic                 regRd;
  logic [31:0]          regRData;
  elt_pkg::elt_token_s  tok;
  elt_pkg::elt_token_s  good;
  elt_pkg::elt_token_s  tk;
  logic [255:0]         signer;
  elt_pkg::elt_fault_s  faults;
  elt_pkg::elt_keydep_s keyDep;
  elt_pkg::elt_keydep_s seenKey;
  elt_pkg::elt_keydep_s expKey;
  logic [1535:0]        macMsg;
  logic                 cryptoValid;
  logic                 cryptoDone;
  logic [127:0]         cryptoMac;
  elt_pkg::elt_commit_s commitData;
  elt_pkg::elt_commit_s seenCommit;
  logic                 commitValid;
  logic                 secsInitialized;
  logic                 gpFault;
  logic                 pfFault;
  logic                 irq;
  logic [31:0]          rd;
  logic                 expZf;
  logic                 expInit;
  logic [31:0]          expRes;
  int                   nCommit;
  int                   nGp;
  int                   nPf;
  int                   cycles;
  int                   n_mismatch;
  int                   n_tests;
  logic [1535:0]        tokenImage     = {48{32'h1357_9bdf}};
  logic [127:0]         secsAttr       = 128'h5;
  logic [255:0]         mrEnclaveFinal = 256'h77;
  logic [255:0]         vendorKeyHash  = 256'ha5;
  logic [127:0]         procSvn        = 128'h10;
  logic [127:0]         ownerEpoch     = 128'h0e;
  logic [127:0]         sealFuses      = 128'hf5;
  logic [15:0]          sigProdId      = 16'h0042;
  logic [15:0]          sigSvn         = 16'h0007;
  logic [2815:0]        sigPadding     = {176{16'hc3a5}};
  localparam logic [255:0] SIGN  = 256'h3c;
  localparam logic [127:0] MAC   = 128'hbeef;
  localparam logic [6:0]   GPSET = 7'h56;

  elt_launch_check i_dut (
    .clock(clock), .nrst(nrst), .regAddr(regAddr), .regWData(regWData), .regWr(regWr),
    .regRd(regRd), .regRData(regRData), .token(tok), .tokenImage(tokenImage),
    .secsAttr(secsAttr), .mrEnclaveFinal(mrEnclaveFinal), .signerDigest(signer),
    .vendorKeyHash(vendorKeyHash), .procSvn(procSvn), .ownerEpoch(ownerEpoch),
    .sealFuses(sealFuses), .sigProdId(sigProdId), .sigSvn(sigSvn), .sigPadding(sigPadding),
    .faults(faults), .keyDep(keyDep), .macMsg(macMsg), .cryptoValid(cryptoValid),
    .cryptoDone(cryptoDone), .cryptoMac(cryptoMac), .commitData(commitData),
    .commitValid(commitValid), .secsInitialized(secsInitialized), .gpFault(gpFault),
    .pfFault(pfFault), .irq(irq)
  );

  //=============================================
  // Clock and timeout
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end

  //=============================================
  // Tasks
  task automatic check(input string what, input logic [4607:0] seen, input logic [4607:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWData <= d;
    @(posedge clock);
    regWr    <= 1'b0;
    #1;
  endtask : regWrite

  task automatic regRead(input logic [7:0] a);
    @(posedge clock);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd   <= 1'b0;
    #1;
    rd = regRData;
  endtask : regRead

  task automatic runOp(input elt_pkg::elt_token_s t, input logic [255:0] sg,
                       input logic [127:0] mac, input elt_pkg::elt_fault_s f);
    logic sent;
    sent    = 1'b0;
    nCommit = 0;
    nGp     = 0;
    nPf     = 0;
    @(posedge clock);
    tok       <= t;
    signer    <= sg;
    cryptoMac <= mac;
    faults    <= f;
    regWrite(elt_pkg::REG_CTRL, 32'h1);
    nGp += gpFault;
    nPf += pfFault;
    repeat (16)
    begin
      @(posedge clock);
      cryptoDone <= cryptoValid && !sent;
      if (cryptoValid && !sent)
      begin
        sent    = 1'b1;
        seenKey = keyDep;
        check("cmac message", macMsg, tokenImage);
      end
      #1;
      if (commitValid)
      begin
        nCommit++;
        seenCommit = commitData;
      end
      nGp += gpFault;
      nPf += pfFault;
    end
  endtask : runOp

  task automatic expectExit(input string name, input logic [31:0] res);
    logic ok;
    ok     = (res === elt_pkg::RES_OK);
    expZf  = !ok;
    expRes = res;
    if (ok)
      expInit = 1'b1;
    check("commit count", nCommit, ok);
    regRead(elt_pkg::REG_RESULT);
    check("result", rd, res);
    regRead(elt_pkg::REG_STATUS);
    check("status", rd, {27'h0, expInit, expZf, 1'b0});
    check("initialised", secsInitialized, expInit);
    regRead(elt_pkg::REG_INT_STAT);
    check("event bits", rd, {30'h0, !ok, 1'b1});
    regWrite(elt_pkg::REG_INT_STAT, 32'hf);
    regRead(elt_pkg::REG_INT_STAT);
    check("event clear", rd, 0);
    $display("Test %s done", name);
  endtask : expectExit

  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  //=============================================
  // Main sequence
  initial
  begin
    nrst = 1'b0;
    regAddr = 8'h00;
    regWData = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    tok = '0;
    signer = '0;
    faults = '0;
    cryptoDone = 1'b0;
    cryptoMac = '0;
    expInit = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    cycles = 0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    regRead(elt_pkg::REG_RESULT);
    check("result reset", rd, elt_pkg::RESULT_RESET);
    regRead(elt_pkg::REG_INT_STAT);
    check("event reset", rd, elt_pkg::INT_RESET);
    regRead(8'h20);
    check("unmapped read", rd, 0);
    good = '0;
    good.valid = 32'h1;
    good.attributes = secsAttr;
    good.processor_security_version = procSvn;
    good.prodId = 16'h1234;
    good.svn = 16'h0009;
    good.keyId = 256'h5a;
    good.maskedMisc = 32'h3;
    good.maskedAttr = 128'h4;
    good.enclave_measurement = mrEnclaveFinal;
    good.signer_measurement = SIGN;
    good.mac = MAC;
    // Bypass commit, masked then unmasked event
    tk = good;
    tk.valid = 32'h0;
    runOp(tk, vendorKeyHash, MAC, '0);
    check("irq masked", irq, 1'b0);
    regWrite(elt_pkg::REG_INT_MASK, 32'hf);
    check("irq unmasked", irq, 1'b1);
    check("commit", seenCommit, {mrEnclaveFinal, vendorKeyHash, sigProdId, sigSvn, sigPadding});
    expectExit("bypass", elt_pkg::RES_OK);
    check("irq cleared", irq, 1'b0);
    runOp(tk, SIGN, MAC, '0);
    expectExit("bypass mismatch", elt_pkg::ERR_INVALID_TOKEN);
    tk = good;
    tk.maskedAttr[elt_pkg::DEBUG_BIT] = 1'b1;
    tk.processor_security_version = procSvn + 128'h1;
    runOp(tk, SIGN, MAC, '0);
    expectExit("debug", elt_pkg::ERR_INVALID_TOKEN);
    tk = good;
    tk.valid[31] = 1'b1;
    tk.attributes = '0;
    runOp(tk, SIGN, MAC, '0);
    expectExit("valid upper", elt_pkg::ERR_INVALID_TOKEN);
    tk = good;
    tk.reserved[0] = 1'b1;
    runOp(tk, SIGN, MAC, '0);
    expectExit("reserved", elt_pkg::ERR_INVALID_TOKEN);
    tk = good;
    tk.processor_security_version = procSvn + 128'h1;
    runOp(tk, SIGN, MAC, '0);
    expectExit("version", elt_pkg::ERR_INVALID_SVN);
    expKey = '0;
    expKey.keyName = 16'h0000;
    expKey.prodId = good.prodId;
    expKey.svn = good.svn;
    expKey.ownerEpoch = ownerEpoch;
    expKey.attributes = good.maskedAttr;
    expKey.keyId = good.keyId;
    expKey.fuses = sealFuses;
    expKey.processor_security_version = good.processor_security_version;
    expKey.misc = good.maskedMisc;
    expKey.padding = {elt_pkg::PAD_DER, {2640{1'b1}}, 16'h0100};
    runOp(good, SIGN, MAC, '0);
    check("key deps", seenKey, expKey);
    check("commit", seenCommit, {mrEnclaveFinal, SIGN, sigProdId, sigSvn, sigPadding});
    expectExit("full", elt_pkg::RES_OK);
    runOp(good, SIGN, MAC ^ 128'h1, '0);
    expectExit("mac", elt_pkg::ERR_INVALID_TOKEN);
    tk = good;
    tk.enclave_measurement[0] = ~tk.enclave_measurement[0];
    tk.attributes = '0;
    runOp(tk, SIGN, MAC, '0);
    expectExit("enclave meas", elt_pkg::ERR_INVALID_MEAS);
    runOp(good, SIGN ^ 256'h1, MAC, '0);
    expectExit("signer meas", elt_pkg::ERR_INVALID_MEAS);
    tk = good;
    tk.attributes[8] = 1'b1;
    runOp(tk, SIGN, MAC, '0);
    expectExit("attributes", elt_pkg::ERR_INVALID_TATTR);
    // Fault causes, one at a time
    for (int i = 0; i < 7; i++)
    begin
      runOp(good, SIGN, MAC, 7'(1 << i));
      check("gp pulse", nGp, GPSET[i]);
      check("pf pulse", nPf, !GPSET[i]);
      check("fault commit", nCommit, 0);
      regRead(elt_pkg::REG_RESULT);
      check("fault result", rd, expRes);
      regRead(elt_pkg::REG_STATUS);
      check("fault status", rd, {27'h0, expInit, expZf, 1'b0});
      regRead(elt_pkg::REG_INT_STAT);
      check("fault events", rd[3:2], {!GPSET[i], GPSET[i]});
      regWrite(elt_pkg::REG_INT_STAT, 32'hf);
    end
    $display("Test faults done");
    give_verdict();
  end
endmodule : elt_launch_check_tb
